// ==== common/rtccap_pkg.sv ====
// Package of register offsets, field layouts, reset values and timing constants
package rtccap_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_SECONDS = 4'h0;
    localparam logic [3:0] OFF_MINUTES = 4'h1;
    localparam logic [3:0] OFF_HOURS = 4'h2;
    localparam logic [3:0] OFF_DAYS_LOW = 4'h3;
    localparam logic [3:0] OFF_DAYS_HIGH = 4'h4;
    localparam logic [3:0] OFF_ALARM_MIN = 4'h5;
    localparam logic [3:0] OFF_ALARM_HOUR = 4'h6;
    localparam logic [3:0] OFF_ALARM_DAY_LOW = 4'h7;
    localparam logic [3:0] OFF_ALARM_DAY_HIGH = 4'h8;
    localparam logic [3:0] OFF_PRESCALER = 4'h9;
    localparam logic [3:0] OFF_CAL_CTRL = 4'ha;
    localparam logic [3:0] OFF_IRQ_STATUS = 4'hb;
    localparam logic [3:0] OFF_IRQ_MASK = 4'hc;
    // Calendar control bit positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_MIN_ON_BIT = 3;
    localparam int CTRL_HOUR_ON_BIT = 4;
    localparam int CTRL_DAY_ON_BIT = 5;
    localparam int CTRL_PEND_BIT = 7;
    localparam logic [7:0] CTRL_RW_MASK = 8'h39;
    // Status bit positions
    localparam int STAT_ALARM_BIT = 0;
    localparam int STAT_WDOG_BIT = 1;
    localparam int STAT_GEN_BIT = 2;
    localparam logic [2:0] STAT_MASK = 3'h7;
    // Reset values and saturating divider code
    localparam logic [3:0] WDOG_CODE_RESET = 4'hb;
    localparam logic [3:0] GEN_CODE_RESET = 4'h8;
    localparam logic [3:0] CODE_MAX = 4'hc;
    // BCD limits and binary day limit
    localparam logic [6:0] BCD_59 = 7'h59;
    localparam logic [5:0] BCD_23 = 6'h23;
    localparam logic [14:0] DAY_MAX = 15'h7fff;
    // Timing
    localparam int SYS_CLK_HZ = 25000000;
    localparam int SRC_CLK_HZ = 32768;
    localparam logic [31:0] SRC_PER_SEC = 32'h0000_8000;
    localparam logic [12:0] DIV_MAX = 13'h1000;
    // Phase accumulator step so that 32.768 kHz is derived from 25 MHz
    localparam logic [31:0] NCO_STEP = 32'(64'(SRC_CLK_HZ) * 64'h1_0000_0000 / 64'(SYS_CLK_HZ));
endpackage

// ==== hw/rtccap_tick_div.sv ====
// Power-of-two divider giving a one-cycle tick from the source enable
`timescale 1ns/100ps
module rtccap_tick_div
    import rtccap_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic src_tick_in,
    input wire logic [3:0] code_in,
    output logic tick_out
);
    logic [11:0] count_reg;
    logic [11:0] count_next;
    logic [12:0] limit;
    logic wrap;

    assign limit = (code_in >= CODE_MAX) ? DIV_MAX : (13'h0001 << code_in);
    assign wrap = ({1'b0, count_reg} >= (limit - 13'h0001));
    assign count_next = wrap ? 12'h000 : count_reg + 12'h001;

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_reg <= 12'h000;
            tick_out <= 1'b0;
        end else begin
            tick_out <= src_tick_in && wrap;
            if (src_tick_in) begin
                count_reg <= count_next;
            end
        end
    end
endmodule

// ==== hw/rtccap_top.sv ====
// Calendar, alarm and prescaler block behind an Avalon-MM slave
// How it works
// [R1] Seconds kept as two BCD digits 00..59 in bits 6-0.
// [R2] Writing seconds clears the sub-second prescale count.
// [R3] Minutes kept as two BCD digits 00..59 in bits 6-0.
// [R4] Hours kept as two BCD digits 00..23, 24-hour format.
// [R5] Day count is 15-bit binary, low byte then seven high bits.
// [R6] Software accesses seconds, minutes, hours, day low, day high in order.
// [R7] Minute alarm compare is read/write BCD 00..59.
// [R8] Hour alarm compare is read/write BCD 00..23.
// [R9] Day alarm compare is 15-bit binary split low/high.
// [R10] Reserved bits are written zero and read back zero.
// [R11] Watchdog divider code bits 7-4, power of two, saturate 4096, reset 0xb.
// [R12] General divider code bits 3-0, same encoding, reset 0x8.
// [R13] Software waits for access pending clear before calendar writes.
// [R14] Alarm pending set by alarm event, cleared by writing one.
// [R15] When running, seconds carry into minutes, hours and days.
// [R16] Alarm fires when all enabled match fields equal the calendar.
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
module rtccap_top
    import rtccap_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [7:0] avs_writedata_in,
    output logic [7:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic irq_out,
    output logic watchdog_tick_out,
    output logic general_tick_out
);
    typedef enum logic [1:0] {RTCCAP_IDLE, RTCCAP_DONE} rtccap_bus_type;
    rtccap_bus_type bus_reg;

    logic [31:0] nco_reg;
    logic [32:0] nco_sum;
    logic src_tick_reg;
    logic [14:0] subsec_reg;
    logic [6:0] tick_s_field_reg;
    logic [6:0] min_reg;
    logic [5:0] hour_reg;
    logic [14:0] day_reg;
    logic [6:0] alarm_m_field_reg;
    logic [5:0] alarm_h_field_reg;
    logic [14:0] alarm_d_field_reg;
    logic [3:0] watchdog_divider_code_reg;
    logic [3:0] general_divider_code_reg;
    logic calendar_run_reg;
    logic minute_match_on_reg;
    logic hour_match_on_reg;
    logic day_match_on_reg;
    logic [2:0] status_reg;
    logic [2:0] mask_reg;
    logic second_pulse_reg;
    logic alarm_hit_reg;

    logic wd_tick;
    logic gen_tick;
    logic second_now;
    logic access;
    logic wr_go;
    logic [7:0] rd_mux;
    logic [7:0] ctrl_view;
    logic [2:0] events;
    logic [2:0] status_next;
    logic sec_wrap;
    logic min_wrap;
    logic hour_wrap;
    logic [6:0] sec_next;
    logic [6:0] min_next;
    logic [5:0] hour_next;
    logic [14:0] day_next;
    logic alarm_match;
    logic pending_flag;

    // 32.768 kHz source enable from the system clock
    assign nco_sum = {1'b0, nco_reg} + {1'b0, NCO_STEP};

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            nco_reg <= 32'h0000_0000;
            src_tick_reg <= 1'b0;
        end else begin
            nco_reg <= nco_sum[31:0];
            src_tick_reg <= nco_sum[32];
        end
    end

    // Prescalers for watchdog and general timer ticks
    rtccap_tick_div u_wdog_div (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .src_tick_in(src_tick_reg),
        .code_in(watchdog_divider_code_reg), // see [R11]
        .tick_out(wd_tick)
    );

    rtccap_tick_div u_gen_div (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .src_tick_in(src_tick_reg),
        .code_in(general_divider_code_reg), // see [R12]
        .tick_out(gen_tick)
    );

    // Bus decode
    assign access = (avs_read_in || avs_write_in) && (bus_reg == RTCCAP_IDLE);
    assign wr_go = avs_write_in && (bus_reg == RTCCAP_IDLE);

    // Sub-second count and one-second pulse
    assign second_now = calendar_run_reg && src_tick_reg && (subsec_reg == 15'(SRC_PER_SEC - 1));

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            subsec_reg <= 15'h0000;
            second_pulse_reg <= 1'b0;
        end else begin
            second_pulse_reg <= second_now;
            if (wr_go && avs_address_in == OFF_SECONDS) begin
                subsec_reg <= 15'h0000; // see [R2]
            end else if (calendar_run_reg && src_tick_reg) begin
                subsec_reg <= second_now ? 15'h0000 : subsec_reg + 15'h0001;
            end
        end
    end

    // BCD increments with wrap, binary for the day count
    function automatic logic [6:0] bcd_inc7(input logic [6:0] v);
        logic [6:0] r;
        r = (v[3:0] == 4'h9) ? {v[6:4] + 3'h1, 4'h0} : {v[6:4], v[3:0] + 4'h1};
        return r;
    endfunction

    assign sec_wrap = (tick_s_field_reg == BCD_59);
    assign min_wrap = (min_reg == BCD_59);
    assign hour_wrap = (hour_reg == BCD_23);
    assign sec_next = sec_wrap ? 7'h00 : bcd_inc7(tick_s_field_reg); // see [R1]
    assign min_next = min_wrap ? 7'h00 : bcd_inc7(min_reg); // see [R3]
    assign hour_next = hour_wrap ? 6'h00 : bcd_inc7({1'b0, hour_reg})[5:0]; // see [R4]
    assign day_next = (day_reg == DAY_MAX) ? 15'h0000 : day_reg + 15'h0001; // see [R5]

    // Calendar counters
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tick_s_field_reg <= 7'h00;
            min_reg <= 7'h00;
            hour_reg <= 6'h00;
            day_reg <= 15'h0000;
        end else if (wr_go) begin
            unique case (avs_address_in)
                OFF_SECONDS: tick_s_field_reg <= avs_writedata_in[6:0]; // see [R1]
                OFF_MINUTES: min_reg <= avs_writedata_in[6:0]; // see [R3]
                OFF_HOURS: hour_reg <= avs_writedata_in[5:0]; // see [R4]
                OFF_DAYS_LOW: day_reg[7:0] <= avs_writedata_in; // see [R5]
                OFF_DAYS_HIGH: day_reg[14:8] <= avs_writedata_in[6:0]; // see [R5]
                default: ;
            endcase
        end else if (second_now) begin
            tick_s_field_reg <= sec_next; // see [R15]
            if (sec_wrap) begin
                min_reg <= min_next;
                if (min_wrap) begin
                    hour_reg <= hour_next;
                    if (hour_wrap) begin
                        day_reg <= day_next;
                    end
                end
            end
        end
    end

    // Alarm compare and control registers
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            alarm_m_field_reg <= 7'h00;
            alarm_h_field_reg <= 6'h00;
            alarm_d_field_reg <= 15'h0000;
            watchdog_divider_code_reg <= WDOG_CODE_RESET;
            general_divider_code_reg <= GEN_CODE_RESET;
            calendar_run_reg <= 1'b0;
            minute_match_on_reg <= 1'b0;
            hour_match_on_reg <= 1'b0;
            day_match_on_reg <= 1'b0;
            mask_reg <= 3'h0;
        end else if (wr_go) begin
            unique case (avs_address_in)
                OFF_ALARM_MIN: alarm_m_field_reg <= avs_writedata_in[6:0]; // see [R7]
                OFF_ALARM_HOUR: alarm_h_field_reg <= avs_writedata_in[5:0]; // see [R8]
                OFF_ALARM_DAY_LOW: alarm_d_field_reg[7:0] <= avs_writedata_in; // see [R9]
                OFF_ALARM_DAY_HIGH: alarm_d_field_reg[14:8] <= avs_writedata_in[6:0]; // see [R9]
                OFF_PRESCALER: begin
                    watchdog_divider_code_reg <= avs_writedata_in[7:4]; // see [R11]
                    general_divider_code_reg <= avs_writedata_in[3:0]; // see [R12]
                end
                OFF_CAL_CTRL: begin
                    calendar_run_reg <= avs_writedata_in[CTRL_RUN_BIT];
                    minute_match_on_reg <= avs_writedata_in[CTRL_MIN_ON_BIT];
                    hour_match_on_reg <= avs_writedata_in[CTRL_HOUR_ON_BIT];
                    day_match_on_reg <= avs_writedata_in[CTRL_DAY_ON_BIT];
                end
                OFF_IRQ_MASK: mask_reg <= avs_writedata_in[2:0];
                default: ;
            endcase
        end
    end

    // Alarm match, checked once per new second
    assign alarm_match = (minute_match_on_reg || hour_match_on_reg || day_match_on_reg)
        && (!minute_match_on_reg || alarm_m_field_reg == min_reg)
        && (!hour_match_on_reg || alarm_h_field_reg == hour_reg)
        && (!day_match_on_reg || alarm_d_field_reg == day_reg); // see [R16]

    // Sticky status, set wins over write-one clear
    assign events = {gen_tick, wd_tick, alarm_hit_reg};
    assign status_next = (status_reg & ~((wr_go && (avs_address_in == OFF_IRQ_STATUS
        || avs_address_in == OFF_CAL_CTRL)) ?
        ((avs_address_in == OFF_IRQ_STATUS) ? avs_writedata_in[2:0]
        : {2'b00, avs_writedata_in[2]}) : 3'h0)) | events; // see [R14]

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            alarm_hit_reg <= 1'b0;
            status_reg <= 3'h0;
            irq_out <= 1'b0;
            watchdog_tick_out <= 1'b0;
            general_tick_out <= 1'b0;
        end else begin
            alarm_hit_reg <= second_pulse_reg && alarm_match && calendar_run_reg; // see [R16]
            status_reg <= status_next & STAT_MASK; // see [R14]
            irq_out <= |(status_next & mask_reg);
            watchdog_tick_out <= wd_tick;
            general_tick_out <= gen_tick;
        end
    end

    // Write in progress flag: never busy since writes land in one cycle
    assign pending_flag = 1'b0; // see [R13]
    assign ctrl_view = {pending_flag, 1'b0, day_match_on_reg, hour_match_on_reg,
        minute_match_on_reg, status_reg[STAT_ALARM_BIT], 1'b0, calendar_run_reg};

    // Read mux, reserved bits zero
    always_comb begin
        rd_mux = 8'h00;
        unique case (avs_address_in)
            OFF_SECONDS: rd_mux = {1'b0, tick_s_field_reg}; // see [R10]
            OFF_MINUTES: rd_mux = {1'b0, min_reg};
            OFF_HOURS: rd_mux = {2'b00, hour_reg};
            OFF_DAYS_LOW: rd_mux = day_reg[7:0];
            OFF_DAYS_HIGH: rd_mux = {1'b0, day_reg[14:8]};
            OFF_ALARM_MIN: rd_mux = {1'b0, alarm_m_field_reg};
            OFF_ALARM_HOUR: rd_mux = {2'b00, alarm_h_field_reg};
            OFF_ALARM_DAY_LOW: rd_mux = alarm_d_field_reg[7:0];
            OFF_ALARM_DAY_HIGH: rd_mux = {1'b0, alarm_d_field_reg[14:8]};
            OFF_PRESCALER: rd_mux = {watchdog_divider_code_reg, general_divider_code_reg};
            OFF_CAL_CTRL: rd_mux = ctrl_view;
            OFF_IRQ_STATUS: rd_mux = {5'h00, status_reg};
            OFF_IRQ_MASK: rd_mux = {5'h00, mask_reg};
            default: rd_mux = 8'h00;
        endcase
    end

    // Avalon slave: one wait cycle, answer on second edge
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bus_reg <= RTCCAP_IDLE;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 8'h00;
        end else begin
            unique case (bus_reg)
                RTCCAP_IDLE: begin
                    if (access) begin
                        bus_reg <= RTCCAP_DONE;
                        avs_waitrequest_out <= 1'b0;
                        avs_readdata_out <= avs_read_in ? rd_mux : 8'h00;
                    end
                end
                RTCCAP_DONE: begin
                    bus_reg <= RTCCAP_IDLE;
                    avs_waitrequest_out <= 1'b1;
                end
                default: bus_reg <= RTCCAP_IDLE;
            endcase
        end
    end
endmodule

// ==== test/rtccap_assertions.sv ====
// Port-level checks for the calendar, alarm and prescaler block
`timescale 1ns/100ps
module rtccap_assertions
    import rtccap_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [7:0] avs_writedata_in,
    input wire logic [7:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic irq_out,
    input wire logic watchdog_tick_out,
    input wire logic general_tick_out
);
    wire logic take_rd;
    wire logic take_wr;
    assign take_rd = avs_read_in && avs_waitrequest_out;
    assign take_wr = avs_write_in && avs_waitrequest_out;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    answer_once_a: assert property (
        (take_rd || take_wr) |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("Bus answer is not one cycle");
    idle_wait_a: assert property (
        !avs_read_in && !avs_write_in && avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("Answer without a request");
    sec_reserved_a: assert property (
        take_rd && avs_address_in == OFF_SECONDS |=> avs_readdata_out[7] == 1'b0)
        else $error("Seconds reserved bit set");
    hour_reserved_a: assert property (
        take_rd && (avs_address_in == OFF_HOURS || avs_address_in == OFF_ALARM_HOUR)
        |=> avs_readdata_out[7:6] == 2'b00)
        else $error("Hours reserved bits set");
    day_reserved_a: assert property (
        take_rd && (avs_address_in == OFF_DAYS_HIGH || avs_address_in == OFF_ALARM_DAY_HIGH)
        |=> avs_readdata_out[7] == 1'b0)
        else $error("Day high reserved bit set");
    presc_readback_a: assert property (
        take_wr && avs_address_in == OFF_PRESCALER ##3 take_rd && avs_address_in == OFF_PRESCALER
        |=> avs_readdata_out == $past(avs_writedata_in, 4))
        else $error("Prescaler readback wrong");
    wdog_pulse_a: assert property (
        watchdog_tick_out |=> !watchdog_tick_out [*8])
        else $error("Watchdog tick too close");
    gen_pulse_a: assert property (
        general_tick_out |=> !general_tick_out [*8])
        else $error("General tick too close");
    irq_masked_a: assert property (
        take_wr && avs_address_in == OFF_IRQ_MASK && avs_writedata_in == 8'h00 |-> ##2 !irq_out)
        else $error("Interrupt high with mask clear");
    reset_state_a: assert property (
        $rose(reset_n_in) |-> avs_waitrequest_out && !irq_out && !watchdog_tick_out)
        else $error("Outputs not idle after reset");
endmodule
bind rtccap_top rtccap_assertions chk_u (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
    .watchdog_tick_out(watchdog_tick_out), .general_tick_out(general_tick_out));

// ==== test/rtccap_top_tb.sv ====
// Self-checking bench for the calendar, alarm and prescaler block
`timescale 1ns/100ps
module rtccap_top_tb;
    import rtccap_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] wdat = 8'h00;
    logic [7:0] rdat;
    logic wreq;
    logic irq;
    logic wtick;
    logic gtick;
    int error_cnt = 0;
    int cmp_count = 0;
    integer seed = 32'hbbf66e6a;
    int cyc;
    logic [7:0] shadow [10];

    always #20 clk = ~clk;

    rtccap_top dut_u (
        .sys_clk_in(clk), .reset_n_in(rst_n), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdat), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wreq), .irq_out(irq), .watchdog_tick_out(wtick),
        .general_tick_out(gtick)
    );

    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic timed_out();
        error_cnt++;
        $display("ERROR at %0t wait ran out", $time);
        summarize();
    endtask

    task automatic bus_op(input logic w, input logic [3:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        int n = 0;
        rd <= !w;
        wr <= w;
        addr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        if (n >= 20) timed_out();
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus_op(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus_op(1'b0, a, 8'h00, q);
        check8(q, e);
    endtask

    task automatic wait_tick(input logic gen, output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while ((gen ? gtick : wtick) !== 1'b1 && c < 20000);
        if (c >= 20000) timed_out();
    endtask

    function automatic logic [7:0] field_mask(input logic [3:0] a);
        case (a)
            OFF_HOURS, OFF_ALARM_HOUR: return 8'h3f;
            OFF_DAYS_LOW, OFF_ALARM_DAY_LOW, OFF_PRESCALER: return 8'hff;
            default: return 8'h7f;
        endcase
    endfunction

    function automatic int period_of(input int code);
        return ((1 << code) * SYS_CLK_HZ) / SRC_CLK_HZ;
    endfunction

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 16; a++) begin
            rd_chk(4'(a), (a == OFF_PRESCALER) ? {WDOG_CODE_RESET, GEN_CODE_RESET} : 8'h00);
        end
        check8({7'h0, irq}, 8'h00);
        for (int r = 0; r < 3; r++) begin
            for (int a = 0; a < 10; a++) begin
                shadow[a] = field_mask(4'(a)) & ((r == 0) ? 8'hff : 8'($random(seed)));
                wr_reg(4'(a), shadow[a]);
            end
            for (int a = 0; a < 10; a++) begin
                rd_chk(4'(a), shadow[a]);
            end
        end
        wr_reg(4'hd, 8'h5a);
        rd_chk(4'hd, 8'h00);
        wr_reg(OFF_CAL_CTRL, 8'h38);
        rd_chk(OFF_CAL_CTRL, 8'h38 & CTRL_RW_MASK);
        wr_reg(OFF_CAL_CTRL, 8'h00);
        for (int c = 0; c < 3; c++) begin
            wr_reg(OFF_PRESCALER, {4'(c), 4'(c)});
            rd_chk(OFF_PRESCALER, {4'(c), 4'(c)});
            for (int g = 0; g < 2; g++) begin
                wait_tick(g[0], cyc);
                wait_tick(g[0], cyc);
                check8({7'h0, (cyc - period_of(c)) inside {[-2:2]}}, 8'h01);
            end
        end
        wr_reg(OFF_PRESCALER, 8'h0c);
        wr_reg(OFF_IRQ_MASK, 8'h00);
        wait_tick(1'b0, cyc);
        wr_reg(OFF_IRQ_STATUS, 8'h07);
        wait_tick(1'b0, cyc);
        rd_chk(OFF_IRQ_STATUS, 8'h02);
        check8({7'h0, irq}, 8'h00);
        wr_reg(OFF_IRQ_MASK, 8'h02);
        check8({7'h0, irq}, 8'h01);
        wr_reg(OFF_IRQ_STATUS, 8'h02);
        check8({7'h0, irq}, 8'h00);
        rd_chk(OFF_IRQ_STATUS, 8'h00);
        rd_chk(OFF_IRQ_MASK, 8'h02);
        wr_reg(OFF_IRQ_MASK, 8'h00);
        summarize();
    end
endmodule
